// *** logic/alu8_core.sv ***
/*
 * Arithmetic and logic datapath of an 8-bit core: byte operations finish
 * one cycle after the request, word operations on a register pair two.
 * Assumes the decoder holds off new requests while busy is high and that
 * the register file writes back lo (and hi for word results) under fmask.
 */
// Summary of operation
// - Add and add-with-carry of two registers write the sum, set Z C N V H, one cycle.
// - Word add of a constant to a high/low pair sets Z C N V S and takes two cycles.
// - Subtract of a register or a constant writes the difference, sets Z C N V H, one cycle.
// - Register subtract with borrow removes source and carry, sets Z C N V H, one cycle.
// - Constant subtract with borrow removes constant and carry, sets Z C N V H, one cycle.
// - Word subtract of a constant from a high/low pair sets Z C N V S, two cycles.
// - And with a register or constant writes the result, sets only Z N V, one cycle.
// - Or with a register or constant writes the result, sets only Z N V, one cycle.
// - Bit setting ors the constant mask in and sets Z N V in one cycle.
// - Bit clearing ands with 0xFF minus the mask and sets Z N V in one cycle.
// - Zero and sign check ands a register with itself, sets Z N V, one cycle.
`default_nettype none
`include "alu8_defs.svh"

module alu8_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire alu8_pkg::alu8_req_t req,
    input wire logic carry_in,
    output var alu8_pkg::alu8_rsp_t rsp,
    output logic busy
);
    import alu8_pkg::*;

    typedef enum logic [0:0] {
        ALU8_IDLE = 1'b0,
        ALU8_WORD = 1'b1
    } alu8_state_t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // 8-bit add with carry-in, returns {c, h, v, result}
    function automatic logic [10:0] alu8_add(input logic [7:0] a, input logic [7:0] b,
                                             input logic ci);
        logic [8:0] s;
        logic [4:0] hs;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        alu8_add = {s[8], hs[4], (a[7] == b[7]) && (s[7] != a[7]), s[7:0]};
    endfunction : alu8_add

    // 8-bit subtract with borrow-in, returns {c, h, v, result}
    function automatic logic [10:0] alu8_sub(input logic [7:0] a, input logic [7:0] b,
                                             input logic bi);
        logic [8:0] s;
        logic [4:0] hs;
        s = {1'b0, a} - {1'b0, b} - {8'h00, bi};
        hs = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bi};
        alu8_sub = {s[8], hs[4], (a[7] != b[7]) && (s[7] != a[7]), s[7:0]};
    endfunction : alu8_sub

    // ----------------------------------------------------------------
    // byte result and flag mask
    // ----------------------------------------------------------------
    logic [10:0] ar;
    logic [7:0] res;
    logic [5:0] fl;
    logic [5:0] fm;
    logic cy;
    logic arith;
    logic [15:0] w_in;
    logic [16:0] w_res;
    logic w_sub;

    // the word pair takes the constant zero-extended from 8 bits
    always_comb begin
        ar = 11'h000;
        res = `ALU8_DATA_RST;
        fm = 6'h00;
        arith = 1'b0;
        cy = 1'b0;
        fl = `ALU8_FLAGS_RST;
        w_in = {req.dst_hi, req.dst};
        w_sub = (req.op == `ALU8_OP_WSUB);
        w_res = w_sub ? ({1'b0, w_in} - {9'h000, req.imm})
                      : ({1'b0, w_in} + {9'h000, req.imm});
        case (req.op)
            `ALU8_OP_ADD: begin
                ar = alu8_add(req.dst, req.src, 1'b0);
                arith = 1'b1;
            end
            `ALU8_OP_ADC: begin
                ar = alu8_add(req.dst, req.src, carry_in);
                arith = 1'b1;
            end
            `ALU8_OP_SUB: begin
                ar = alu8_sub(req.dst, req.src, 1'b0);
                arith = 1'b1;
            end
            `ALU8_OP_SUBK: begin
                ar = alu8_sub(req.dst, req.imm, 1'b0);
                arith = 1'b1;
            end
            `ALU8_OP_SUBB: begin
                ar = alu8_sub(req.dst, req.src, carry_in);
                arith = 1'b1;
            end
            `ALU8_OP_SUBBK: begin
                ar = alu8_sub(req.dst, req.imm, carry_in);
                arith = 1'b1;
            end
            `ALU8_OP_AINV: begin
                ar = alu8_sub(8'h00, req.dst, 1'b0);
                arith = 1'b1;
            end
            `ALU8_OP_AND: res = req.dst & req.src;
            `ALU8_OP_ANDK: res = req.dst & req.imm;
            `ALU8_OP_OR: res = req.dst | req.src;
            `ALU8_OP_ORK: res = req.dst | req.imm;
            `ALU8_OP_BSET: res = req.dst | req.imm;
            `ALU8_OP_BCLR: res = req.dst & (`ALU8_ALL_ONES - req.imm);
            `ALU8_OP_ZCHK: res = req.dst & req.dst;
            `ALU8_OP_XOR: res = req.dst ^ req.src;
            `ALU8_OP_INC: res = req.dst + 8'h01;
            `ALU8_OP_MINUS1: res = req.dst - 8'h01;
            `ALU8_OP_BINV: begin
                res = `ALU8_ALL_ONES - req.dst;
                cy = 1'b1;
            end
            default: res = req.dst;
        endcase
        if (arith) begin
            res = ar[7:0];
            fl[`ALU8_F_C] = ar[10];
            fl[`ALU8_F_H] = ar[9];
            fl[`ALU8_F_V] = ar[8];
            fm = 6'h2F; // Z C N V H
        end else begin
            fl[`ALU8_F_C] = cy; // inversion always leaves carry set
            fm = cy ? 6'h0F : 6'h0E; // logic group touches Z N V, inversion also C
            // inc wraps 7F->80, dec wraps 80->7F: signed overflow
            if (req.op == `ALU8_OP_INC) fl[`ALU8_F_V] = (req.dst == 8'h7F);
            if (req.op == `ALU8_OP_MINUS1) fl[`ALU8_F_V] = (req.dst == 8'h80);
        end
        fl[`ALU8_F_Z] = (res == 8'h00);
        fl[`ALU8_F_N] = res[7];
        fl[`ALU8_F_S] = fl[`ALU8_F_N] ^ fl[`ALU8_F_V];
    end

    // ----------------------------------------------------------------
    // sequencing and output registers
    // ----------------------------------------------------------------
    alu8_state_t state_q, state_d;
    alu8_rsp_t rsp_q, rsp_d;
    alu8_rsp_t wpend_q, wpend_d;
    logic busy_q, busy_d;
    logic is_word;

    // a word op holds its result one extra cycle so it lands at the second edge
    always_comb begin
        is_word = (req.op == `ALU8_OP_WADD) || (req.op == `ALU8_OP_WSUB);
        state_d = state_q;
        rsp_d = '0;
        wpend_d = wpend_q;
        busy_d = 1'b0;
        unique case (state_q)
            ALU8_IDLE: begin
                if (req.valid && is_word) begin
                    wpend_d.valid = 1'b1;
                    wpend_d.word = 1'b1;
                    wpend_d.lo = w_res[7:0];
                    wpend_d.hi = w_res[15:8];
                    wpend_d.flags[`ALU8_F_C] = w_res[16];
                    wpend_d.flags[`ALU8_F_Z] = (w_res[15:0] == 16'h0000);
                    wpend_d.flags[`ALU8_F_N] = w_res[15];
                    wpend_d.flags[`ALU8_F_V] = w_sub ? (w_in[15] & ~w_res[15])
                                                     : (~w_in[15] & w_res[15]);
                    wpend_d.flags[`ALU8_F_S] = w_res[15] ^ wpend_d.flags[`ALU8_F_V];
                    wpend_d.flags[`ALU8_F_H] = 1'b0;
                    wpend_d.fmask = 6'h1F; // Z C N V S
                    busy_d = 1'b1;
                    state_d = ALU8_WORD;
                end else if (req.valid) begin
                    rsp_d.valid = 1'b1;
                    rsp_d.lo = res;
                    rsp_d.hi = 8'h00;
                    rsp_d.flags = fl;
                    rsp_d.fmask = fm;
                end
            end
            ALU8_WORD: begin
                rsp_d = wpend_q; // second cycle
                wpend_d = '0;
                state_d = ALU8_IDLE;
            end
        endcase
    end

    // synchronous reset clears all control state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ALU8_IDLE;
            rsp_q <= '0;
            wpend_q <= '0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rsp_q <= rsp_d;
            wpend_q <= wpend_d;
            busy_q <= busy_d;
        end
    end

    assign rsp = rsp_q;
    assign busy = busy_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_word_req;
        req.valid && !busy && is_word && state_q == ALU8_IDLE;
    endsequence

    // busy cycle first, then the pair result
    sequence s_word_done;
        busy && !rsp.valid ##1 rsp.valid && rsp.word;
    endsequence

    a_word_two_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        s_word_req |=> s_word_done)
        else $error("word result not on second cycle");
    a_word_mask: assert property (@(posedge clk) disable iff (!rst_n)
        rsp.valid && rsp.word |-> rsp.fmask == 6'h1F)
        else $error("word flag mask wrong");
    a_byte_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && !is_word && state_q == ALU8_IDLE |=> rsp.valid && !rsp.word)
        else $error("byte result late");
    a_add_sum: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && state_q == ALU8_IDLE && req.op == `ALU8_OP_ADD
        |=> rsp.lo == 8'($past(req.dst) + $past(req.src)))
        else $error("add sum wrong");
    a_sub_diff: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && state_q == ALU8_IDLE && req.op == `ALU8_OP_SUBK
        |=> rsp.lo == 8'($past(req.dst) - $past(req.imm)))
        else $error("constant subtract wrong");
    a_borrow_subtract: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && state_q == ALU8_IDLE && req.op == `ALU8_OP_SUBB
        |=> rsp.lo == 8'($past(req.dst) - $past(req.src) - {7'h00, $past(carry_in)}))
        else $error("subtract with borrow wrong");
    a_clr_mask: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && state_q == ALU8_IDLE && req.op == `ALU8_OP_BCLR
        |=> rsp.lo == ($past(req.dst) & ~$past(req.imm)) && rsp.fmask == 6'h0E)
        else $error("bit clear wrong");
    a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
        rsp.valid && !rsp.word |-> rsp.flags[`ALU8_F_Z] == (rsp.lo == 8'h00))
        else $error("zero flag mismatch");
    a_inv_carry: assert property (@(posedge clk) disable iff (!rst_n)
        req.valid && state_q == ALU8_IDLE && req.op == `ALU8_OP_BINV
        |=> rsp.flags[`ALU8_F_C] && rsp.fmask == 6'h0F)
        else $error("inversion carry wrong");
endmodule : alu8_core

`default_nettype wire

// *** logic/alu8_defs.svh ***
/*
 * Constants of the 8-bit arithmetic and logic unit: operation codes,
 * flag bit positions, reset values and latencies.
 * Assumes it is included by its bare name before the package.
 */
`ifndef ALU8_DEFS_SVH
`define ALU8_DEFS_SVH

// operation codes
`define ALU8_OP_ADD     5'h00
`define ALU8_OP_ADC     5'h01
`define ALU8_OP_WADD    5'h02
`define ALU8_OP_SUB     5'h03
`define ALU8_OP_SUBK    5'h04
`define ALU8_OP_SUBB    5'h05
`define ALU8_OP_SUBBK   5'h06
`define ALU8_OP_WSUB    5'h07
`define ALU8_OP_AND     5'h08
`define ALU8_OP_ANDK    5'h09
`define ALU8_OP_OR      5'h0A
`define ALU8_OP_ORK     5'h0B
`define ALU8_OP_XOR     5'h0C
`define ALU8_OP_BINV    5'h0D
`define ALU8_OP_AINV    5'h0E
`define ALU8_OP_BSET    5'h0F
`define ALU8_OP_BCLR    5'h10
`define ALU8_OP_INC     5'h11
`define ALU8_OP_MINUS1  5'h12
`define ALU8_OP_ZCHK    5'h13

// flag positions in the 6-bit flag vector
`define ALU8_F_C 0
`define ALU8_F_Z 1
`define ALU8_F_N 2
`define ALU8_F_V 3
`define ALU8_F_S 4
`define ALU8_F_H 5

`define ALU8_ALL_ONES   8'hFF
`define ALU8_FLAGS_RST  6'h00
`define ALU8_DATA_RST   8'h00
`define ALU8_LAT_BYTE   1
`define ALU8_LAT_WORD   2

`endif

// *** logic/alu8_pkg.sv ***
/*
 * Types of the 8-bit arithmetic and logic unit.
 * Assumes alu8_defs.svh is on the include path.
 */
`default_nettype none
`include "alu8_defs.svh"

package alu8_pkg;
    // request from the decoder and register file
    typedef struct packed {
        logic       valid;
        logic [4:0] op;
        logic [7:0] dst;
        logic [7:0] src;
        logic [7:0] dst_hi;
        logic [7:0] imm;
    } alu8_req_t;

    // result handed back for write-back
    typedef struct packed {
        logic       valid;
        logic       word;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [5:0] flags;
        logic [5:0] fmask;
    } alu8_rsp_t;
endpackage : alu8_pkg

`default_nettype wire

// *** testbench/alu8_core_tb.sv ***
/*
 * Self-checking bench of the 8-bit arithmetic and logic unit.
 * Assumes alu8_pkg and alu8_core are compiled first; the bench drives all ports itself.
 */
`default_nettype none

module alu8_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import alu8_pkg::*;

    logic clk;
    logic rst_n;
    logic carry_in;
    logic busy;
    alu8_req_t req;
    alu8_rsp_t rsp, e0, e1;
    logic f0, f1, be;
    int err_total, n_compared;

    // 10 MHz clock
    always #50 clk = ~clk;

    alu8_core dut (.clk(clk), .rst_n(rst_n), .req(req), .carry_in(carry_in),
        .rsp(rsp), .busy(busy));

    // --------------------------------------------------------------
    // reference model and shared drivers
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("Error at %0t ns: got %h, want %h", $time, seen, want);
        end
    endtask : chk

    // expected response, worked out bit by bit from the operation
    function automatic alu8_rsp_t model(input logic [4:0] op, input logic [7:0] d, s, dh, k,
        input logic ci);
        alu8_rsp_t e;
        logic [8:0] r;
        logic [4:0] h;
        logic [16:0] w;
        logic [7:0] b;
        logic c, sb;
        e = '0;
        e.valid = 1'h1;
        e.lo = d;
        e.fmask = 6'h0E;
        b = (op inside {5'h04, 5'h06, 5'h09, 5'h0B, 5'h0F, 5'h10}) ? k : s;
        c = (op inside {5'h01, 5'h05, 5'h06}) ? ci : 1'h0;
        sb = op inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h0E};
        // negation is zero minus the value
        if (op == 5'h0E) begin
            b = d;
            d = 8'h00;
        end
        if (op <= 5'h01 || sb) begin
            r = sb ? {1'h0, d} - {1'h0, b} - c : {1'h0, d} + {1'h0, b} + c;
            h = sb ? {1'h0, d[3:0]} - {1'h0, b[3:0]} - c : {1'h0, d[3:0]} + {1'h0, b[3:0]} + c;
            e.lo = r[7:0];
            e.fmask = 6'h2F;
            e.flags[0] = r[8];
            e.flags[5] = h[4];
            e.flags[3] = ((d[7] ^ b[7]) == sb) && (r[7] != d[7]);
        end
        case (op)
            5'h08, 5'h09: e.lo = d & b;
            5'h0A, 5'h0B, 5'h0F: e.lo = d | b;
            5'h0C: e.lo = d ^ s;
            5'h10: e.lo = d & (8'hFF - k);
            5'h11: {e.lo, e.flags[3]} = {d + 8'h01, d == 8'h7F};
            5'h12: {e.lo, e.flags[3]} = {d - 8'h01, d == 8'h80};
            5'h0D: {e.lo, e.fmask, e.flags[0]} = {8'hFF - d, 6'h0F, 1'h1};
            5'h02, 5'h07: begin
                w = (op == 5'h02) ? {1'h0, dh, d} + {9'h000, k} : {1'h0, dh, d} - {9'h000, k};
                {e.word, e.hi, e.lo, e.fmask, e.flags[0]} = {1'h1, w[15:0], 6'h1F, w[16]};
                e.flags[3] = (op == 5'h02) ? ~dh[7] & w[15] : dh[7] & ~w[15];
            end
            default: ;
        endcase
        e.flags[1] = e.word ? ({e.hi, e.lo} == 16'h0000) : (e.lo == 8'h00);
        e.flags[2] = e.word ? e.hi[7] : e.lo[7];
        e.flags[4] = e.flags[2] ^ e.flags[3];
        e.flags = e.flags & e.fmask;
        return e;
    endfunction : model

    // one cycle: drive a request, judge what the previous ones left at the ports
    task automatic step(input logic v, input logic [4:0] op, input logic [7:0] d, s, dh, k,
        input logic ci);
        alu8_rsp_t e;
        logic tk;
        @(posedge clk);
        req <= {v, op, d, s, dh, k};
        carry_in <= ci;
        #1;
        chk(rsp.valid, e0.valid);
        if (e0.valid === 1'h1) begin
            chk({rsp.word, rsp.hi, rsp.lo, rsp.fmask}, {e0.word, e0.hi, e0.lo, e0.fmask});
            if (f0) chk(rsp.flags & rsp.fmask, e0.flags);
        end
        chk(busy, be);
        {e0, f0, e1, f1} = {e1, f1, 31'h0};
        e = model(op, d, s, dh, k, ci);
        // a request seen while busy is dropped, so the model drops it too
        tk = v && !be;
        be = tk && e.word;
        if (tk && e.word) {e1, f1} = {e, op <= 5'h13};
        else if (tk) {e0, f0} = {e, op <= 5'h13};
    endtask : step

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'h0;
        req <= '0;
        repeat (11) @(posedge clk);
        rst_n <= 1'h1;
        #1;
        chk(rsp, '0);
        chk(busy, 1'h0);
        {e0, e1, f0, f1, be} = '0;
    endtask : do_reset

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_arith();
        step(1, 5'h00, 8'h7F, 8'h01, 8'h00, 8'h00, 1'h0);
        step(1, 5'h00, 8'hFF, 8'h01, 8'h00, 8'h00, 1'h0);
        step(1, 5'h01, 8'h0F, 8'h00, 8'h00, 8'h00, 1'h1);
        step(1, 5'h03, 8'h80, 8'h01, 8'h00, 8'h00, 1'h1);
        step(1, 5'h04, 8'h00, 8'h00, 8'h00, 8'h01, 1'h0);
        step(1, 5'h05, 8'h10, 8'h0F, 8'h00, 8'h00, 1'h1);
        step(1, 5'h05, 8'h00, 8'h00, 8'h00, 8'h00, 1'h1);
        step(1, 5'h06, 8'h50, 8'h00, 8'h00, 8'h4F, 1'h1);
        step(1, 5'h0E, 8'h80, 8'h00, 8'h00, 8'h00, 1'h0);
        step(1, 5'h0E, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0);
        step(1, 5'h0D, 8'h5A, 8'h00, 8'h00, 8'h00, 1'h0);
        step(0, 5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0);
        $display("test arith done");
    endtask : t_arith

    task automatic t_logic();
        step(1, 5'h08, 8'hF0, 8'h0F, 8'h00, 8'h00, 1'h1);
        step(1, 5'h09, 8'hC3, 8'h00, 8'h00, 8'h81, 1'h1);
        step(1, 5'h0A, 8'h01, 8'h02, 8'h00, 8'h00, 1'h1);
        step(1, 5'h0B, 8'h00, 8'h00, 8'h00, 8'h80, 1'h1);
        step(1, 5'h0F, 8'h11, 8'h00, 8'h00, 8'h06, 1'h0);
        step(1, 5'h10, 8'hFF, 8'h00, 8'h00, 8'h0F, 1'h0);
        step(1, 5'h13, 8'h80, 8'h00, 8'h00, 8'h00, 1'h0);
        step(1, 5'h0C, 8'hA5, 8'hA5, 8'h00, 8'h00, 1'h0);
        step(1, 5'h11, 8'h7F, 8'h00, 8'h00, 8'h00, 1'h1);
        step(1, 5'h12, 8'h80, 8'h00, 8'h00, 8'h00, 1'h1);
        step(1, 5'h12, 8'h01, 8'h00, 8'h00, 8'h00, 1'h0);
        step(1, 5'h1F, 8'h3C, 8'h00, 8'h00, 8'h00, 1'h0);
        step(0, 5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0);
        $display("test logic done");
    endtask : t_logic

    // word results come two cycles on; a byte request during busy must vanish
    task automatic t_word();
        step(1, 5'h02, 8'hFF, 8'h00, 8'hFF, 8'h01, 1'h0);
        step(1, 5'h00, 8'h01, 8'h01, 8'h00, 8'h00, 1'h0);
        step(1, 5'h02, 8'hFF, 8'h00, 8'h7F, 8'h01, 1'h0);
        step(0, 5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0);
        step(1, 5'h07, 8'h00, 8'h00, 8'h00, 8'h01, 1'h1);
        step(0, 5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0);
        step(1, 5'h07, 8'h00, 8'h00, 8'h80, 8'h01, 1'h0);
        step(0, 5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0);
        step(1, 5'h00, 8'h20, 8'h30, 8'h00, 8'h00, 1'h0);
        step(0, 5'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0);
        // reset lands while a word result is still in flight
        step(1, 5'h07, 8'h34, 8'h00, 8'h12, 8'hFF, 1'h0);
        do_reset();
        $display("test word done");
    endtask : t_word

    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    initial begin
        {clk, rst_n, carry_in, req, e0, e1, f0, f1, be} = '0;
        err_total = 0;
        n_compared = 0;
        do_reset();
        t_arith();
        t_logic();
        t_word();
        t_arith();
        results();
    end

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #4000000;
        err_total++;
        $display("Error at %0t ns: run timed out", $time);
        results();
    end
endmodule : alu8_core_tb

`default_nettype wire
